/* File: design/fmc_cfg.svh */
// register map, field positions, reset values and timing counts
// assumes 32-bit classic wishbone, registers at index*4
`ifndef FMC_CFG_SVH
`define FMC_CFG_SVH
// register indices, byte address is index*4
`define FMC_IDX_FWD_OFF 6'h20
`define FMC_IDX_MODE 6'h21
`define FMC_IDX_SYNC_STS 6'h22
`define FMC_IDX_IRQ_EN 6'h23
`define FMC_IDX_IRQ_PEND 6'h24
`define FMC_IDX_EVT_STS 6'h28
`define FMC_IDX_EVT_MASK 6'h29
// reset values, except FMC_RST_MODE: the mode register resets to 8'h01
`define FMC_RST_FWD_OFF 8'hf0
`define FMC_RST_MODE 8'h03
`define FMC_RST_IRQ_EN 8'h00
`define FMC_RST_EVT_MASK 8'h00
// field positions
`define FMC_FWD_OFF_LSB 4
`define FMC_MODE_RR_BIT 0
`define FMC_MODE_SYNC_LSB 2
`define FMC_MODE_ASAP_BIT 6
`define FMC_STS_SYNC_BIT 0
`define FMC_STS_FAIL_BIT 2
`define FMC_IE_TX_BIT 4
`define FMC_IE_GLOBAL_BIT 7
`define FMC_PEND_GLOBAL_BIT 7
`define FMC_EVT_LOST_BIT 0
`define FMC_EVT_GAIN_BIT 1
// sync loss timeout
`define FMC_CLK_PERIOD_NS 8
`define FMC_SYNC_LOSS_NS 100000
`define FMC_SYNC_LOSS_CYC (`FMC_SYNC_LOSS_NS / `FMC_CLK_PERIOD_NS)
`endif

/* File: design/fmc_pkg.sv */
// types shared by the forwarding mode control block
// assumes fmc_cfg.svh supplies the numbers
package fmc_pkg;
	// synchronized forwarding selection
	typedef enum logic [1:0] {
		FMC_SYNC_OFF,
		FMC_SYNC_BASIC,
		FMC_SYNC_INTERLEAVE,
		FMC_SYNC_CONCAT
	} fmc_sync_e;
	// wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} fmc_wb_req_s;
	// wishbone answer to the master
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} fmc_wb_rsp_s;
endpackage

/* File: design/fmc_forward_ctl.sv */
// forwarding mode control: registers, grant engine, sync status, interrupt
// assumes line/sync ready levels from receive ports drop after their grant
`timescale 1ns/1ns
`include "fmc_cfg.svh"
module fmc_forward_ctl #(
	parameter int unsigned SYNC_LOSS_CYC = `FMC_SYNC_LOSS_CYC,
	parameter int unsigned PORTS = 4
)(
	input wire logic ref_clk,
	input wire logic reset,
	input wire fmc_pkg::fmc_wb_req_s wb_req,
	output fmc_pkg::fmc_wb_rsp_s wb_rsp,
	input wire logic [PORTS-1:0] line_ready,
	input wire logic [PORTS-1:0] sync_ready,
	input wire logic tx_ready,
	input wire logic [PORTS-1:0] rx_port_irq,
	input wire logic tx_port_irq,
	output logic [PORTS-1:0] line_grant,
	output logic [PORTS-1:0] sync_grant,
	output logic irq
);
	// next port after last in rotating order, one-hot
	function automatic logic [3:0] fmc_rr(input logic [3:0] req, input logic [1:0] last);
		logic [3:0] g;
		logic [1:0] idx;
		g = 4'h0;
		for (int i = 1; i <= 4; i++)
		begin
			idx = 2'(last + 2'(i));
			if (g == 4'h0 && req[idx])
				g[idx] = 1'b1;
		end
		return g;
	endfunction

	// one-hot to index
	function automatic logic [1:0] fmc_idx(input logic [3:0] oh);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 0; i < 4; i++)
			if (oh[i])
				r = 2'(i);
		return r;
	endfunction

	logic [3:0] forward_off; // per-port forwarding disable
	logic send_when_ready; // as-available option
	fmc_pkg::fmc_sync_e sync_forward_mode; // sync selection
	logic round_robin_enable; // best-effort selection
	logic sync_failure_flag; // clear-on-read failure
	logic sync_active; // engine delivering synced video
	logic frame_ok; // one synced frame already sent
	logic [7:0] irq_enable; // global and per-source enables
	logic [1:0] evt_sts; // sticky own events
	logic [1:0] evt_mask; // own event mask
	logic [31:0] wait_cnt; // partial-ready wait counter
	logic [3:0] round_left; // ports still owed a line this round
	logic [1:0] last_port; // last port granted by the rotating best-effort or as-available selection
	logic busy; // grant issued last cycle
	logic loss_evt; // sync loss detected this cycle

	logic acc; // valid access this cycle
	logic wr; // write strobe on byte lane 0
	logic rd; // read taking effect
	logic [5:0] idx; // register index
	logic [3:0] enabled; // ports allowed to forward
	logic [3:0] line_en; // enabled ports with a line
	logic [3:0] sync_en; // enabled ports with a sync packet
	logic all_line; // every enabled port has a line
	logic all_sync; // every enabled port has a sync packet
	logic sync_on; // any synchronized mode selected
	logic [4:0] src; // source interrupt levels
	logic pending; // global pending
	logic [7:0] rd_mux; // read value before registering

	// bus decode, ack on the cycle after strobe
	// a write lands at the edge where the master sees ack, not one edge early
	assign acc = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	assign wr = wb_req.cyc && wb_req.stb && wb_rsp.ack && wb_req.we && wb_req.sel[0];
	assign rd = acc && !wb_req.we;
	assign idx = wb_req.adr[7:2];

	// port enable and readiness terms
	assign enabled = ~forward_off;
	assign line_en = line_ready & enabled;
	assign sync_en = sync_ready & enabled;
	assign all_line = (enabled != 4'h0) && (line_en == enabled);
	assign all_sync = (enabled != 4'h0) && (sync_en == enabled);
	assign sync_on = (sync_forward_mode != fmc_pkg::FMC_SYNC_OFF);

	// loss: some enabled port kept waiting too long for the rest
	assign loss_evt = sync_on && (wait_cnt >= SYNC_LOSS_CYC - 1) && (sync_en != 4'h0) && !all_sync;

	// own events fold into the transmitter source
	assign src = {tx_port_irq || ((evt_sts & evt_mask) != 2'h0), rx_port_irq};
	assign pending = ((src & irq_enable[4:0]) != 5'h0);

	// read mux, reserved bits zero
	always_comb
	begin
		rd_mux = 8'h00;
		unique case (idx)
			`FMC_IDX_FWD_OFF: rd_mux = {forward_off, 4'h0};
			`FMC_IDX_MODE:
			begin
				rd_mux[`FMC_MODE_ASAP_BIT] = send_when_ready;
				rd_mux[`FMC_MODE_SYNC_LSB +: 2] = sync_forward_mode;
				rd_mux[`FMC_MODE_RR_BIT] = round_robin_enable;
			end
			`FMC_IDX_SYNC_STS:
			begin
				rd_mux[`FMC_STS_FAIL_BIT] = sync_failure_flag;
				rd_mux[`FMC_STS_SYNC_BIT] = sync_active && sync_on;
			end
			`FMC_IDX_IRQ_EN: rd_mux = irq_enable;
			`FMC_IDX_IRQ_PEND: rd_mux = {pending, 2'h0, src};
			`FMC_IDX_EVT_STS: rd_mux = {6'h00, evt_sts};
			`FMC_IDX_EVT_MASK: rd_mux = {6'h00, evt_mask};
			default: rd_mux = 8'h00; // unmapped reads zero
		endcase
	end

	// wishbone answer, every address acked, one cycle
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			wb_rsp <= '0;
		else
		begin
			wb_rsp.ack <= acc;
			wb_rsp.dat <= rd ? {24'h000000, rd_mux} : 32'h00000000;
		end
	end

	// control registers
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			forward_off <= 4'(`FMC_RST_FWD_OFF >> `FMC_FWD_OFF_LSB);
			send_when_ready <= 1'b0;
			sync_forward_mode <= fmc_pkg::FMC_SYNC_OFF;
			round_robin_enable <= 1'b1;
			irq_enable <= `FMC_RST_IRQ_EN;
			evt_mask <= 2'h0;
		end
		else if (wr)
		begin
			// writes to read-only or unmapped words are dropped
			if (idx == `FMC_IDX_FWD_OFF)
				forward_off <= wb_req.dat[`FMC_FWD_OFF_LSB +: 4];
			if (idx == `FMC_IDX_MODE)
			begin
				send_when_ready <= wb_req.dat[`FMC_MODE_ASAP_BIT];
				sync_forward_mode <= fmc_pkg::fmc_sync_e'(wb_req.dat[`FMC_MODE_SYNC_LSB +: 2]);
				round_robin_enable <= wb_req.dat[`FMC_MODE_RR_BIT];
			end
			if (idx == `FMC_IDX_IRQ_EN)
				irq_enable <= wb_req.dat[7:0] & 8'h9f;
			if (idx == `FMC_IDX_EVT_MASK)
				evt_mask <= wb_req.dat[1:0];
		end
	end

	// grant engine; one grant then one idle cycle for the source to drop ready
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			line_grant <= 4'h0;
			sync_grant <= 4'h0;
			round_left <= 4'h0;
			last_port <= 2'h3;
			busy <= 1'b0;
		end
		else
		begin
			line_grant <= 4'h0;
			sync_grant <= 4'h0;
			busy <= 1'b0;
			if (!sync_on)
				round_left <= 4'h0;
			if (busy || !tx_ready)
			begin
				// hold, output stalled or source still settling
			end
			else if (sync_on)
			begin
				if (all_sync)
				begin
					// sync packets always wait for every port
					sync_grant <= enabled;
					busy <= 1'b1;
				end
				else if (sync_forward_mode == fmc_pkg::FMC_SYNC_CONCAT)
				begin
					// one concatenated line from all ports
					if (all_line)
					begin
						line_grant <= enabled;
						busy <= 1'b1;
					end
				end
				else if (send_when_ready)
				begin
					// no waiting for the other ports
					if (line_en != 4'h0)
					begin
						line_grant <= fmc_rr(line_en, last_port);
						last_port <= fmc_idx(fmc_rr(line_en, last_port));
						busy <= 1'b1;
					end
				end
				else if ((round_left & enabled) != 4'h0)
				begin
					// drain the round in port order
					line_grant <= fmc_rr(round_left & enabled, 2'h3);
					round_left <= round_left & ~fmc_rr(round_left & enabled, 2'h3);
					busy <= 1'b1;
				end
				else if (all_line)
				begin
					// every port ready, start a new round
					line_grant <= fmc_rr(enabled, 2'h3);
					round_left <= enabled & ~fmc_rr(enabled, 2'h3);
					busy <= 1'b1;
				end
			end
			else if (round_robin_enable && line_en != 4'h0)
			begin
				// best effort, no synchronization
				line_grant <= fmc_rr(line_en, last_port);
				last_port <= fmc_idx(fmc_rr(line_en, last_port));
				busy <= 1'b1;
			end
		end
	end

	// wait counter for partial sync readiness
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			wait_cnt <= 32'h00000000;
		else if (!sync_on || sync_en == 4'h0 || all_sync || loss_evt)
			wait_cnt <= 32'h00000000;
		else
			wait_cnt <= wait_cnt + 32'h00000001;
	end

	// sync state: active on a synced frame start, frame_ok after a full frame
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sync_active <= 1'b0;
			frame_ok <= 1'b0;
		end
		else if (!sync_on || loss_evt)
		begin
			sync_active <= 1'b0;
			frame_ok <= 1'b0;
		end
		else if (sync_grant != 4'h0)
		begin
			sync_active <= 1'b1;
			frame_ok <= frame_ok || sync_active;
		end
	end

	// failure flag; a new failure wins over the read clear
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			sync_failure_flag <= 1'b0;
		else if (loss_evt && frame_ok)
			sync_failure_flag <= 1'b1;
		else if (rd && idx == `FMC_IDX_SYNC_STS)
			sync_failure_flag <= 1'b0;
	end

	// own sticky events, set beats read clear
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			evt_sts <= 2'h0;
		else
		begin
			if (rd && idx == `FMC_IDX_EVT_STS)
				evt_sts <= 2'h0;
			if (loss_evt && sync_active)
				evt_sts[`FMC_EVT_LOST_BIT] <= 1'b1;
			if (sync_grant != 4'h0 && !sync_active)
				evt_sts[`FMC_EVT_GAIN_BIT] <= 1'b1;
		end
	end

	// interrupt line, registered
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= irq_enable[`FMC_IE_GLOBAL_BIT] && pending;
	end
endmodule // fmc_forward_ctl

/* File: verification/fmc_forward_ctl_monitor.sv */
// checker on the ports of the forwarding control block
// assumes one clock domain and the bind below
`timescale 1ns/1ns
module fmc_forward_ctl_monitor #(
	parameter int unsigned PORTS = 4
)(
	input wire logic ref_clk,
	input wire logic reset,
	input wire fmc_pkg::fmc_wb_req_s wb_req,
	input wire fmc_pkg::fmc_wb_rsp_s wb_rsp,
	input wire logic [PORTS-1:0] line_ready,
	input wire logic [PORTS-1:0] sync_ready,
	input wire logic tx_ready,
	input wire logic [PORTS-1:0] rx_port_irq,
	input wire logic tx_port_irq,
	input wire logic [PORTS-1:0] line_grant,
	input wire logic [PORTS-1:0] sync_grant,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// a request taken, then exactly one answer pulse
	sequence s_take;
		wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	endsequence
	sequence s_pulse;
		wb_rsp.ack ##1 !wb_rsp.ack;
	endsequence
	a_ack_next_edge: assert property (s_take |=> s_pulse)
		else $error("ack not a one cycle answer");
	a_ack_has_req: assert property (wb_rsp.ack |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack without request");
	a_idle_data_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
		else $error("read data outside ack");
	// grants are single cycles with an idle cycle after
	a_grant_gap: assert property ((|line_grant || |sync_grant) |=> !(|{line_grant, sync_grant}))
		else $error("grants back to back");
	a_grant_tx: assert property ((|line_grant || |sync_grant) |-> $past(tx_ready))
		else $error("grant while output stalled");
	// a grant only for a port that had something waiting
	a_line_cause: assert property ((line_grant & ~$past(line_ready)) == '0)
		else $error("line grant without ready line");
	a_sync_cause: assert property ((sync_grant & ~$past(sync_ready)) == '0)
		else $error("sync grant without ready sync");
	a_irq_cause: assert property (irq |-> $past(|{rx_port_irq, tx_port_irq}))
		else $error("irq without source");
endmodule // fmc_forward_ctl_monitor
bind fmc_forward_ctl fmc_forward_ctl_monitor #(.PORTS(PORTS)) u_mon (.ref_clk(ref_clk),
	.reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp), .line_ready(line_ready),
	.sync_ready(sync_ready), .tx_ready(tx_ready), .rx_port_irq(rx_port_irq),
	.tx_port_irq(tx_port_irq), .line_grant(line_grant), .sync_grant(sync_grant), .irq(irq));

/* File: verification/fmc_src_model.sv */
// receive port model: holds lines and sync packets until granted
// assumes the bench pulses the load inputs for one cycle
`timescale 1ns/1ns
module fmc_src_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [3:0] ld_line,
	input wire logic [3:0] ld_sync,
	input wire logic [3:0] line_grant,
	input wire logic [3:0] sync_grant,
	output logic [3:0] line_ready,
	output logic [3:0] sync_ready
);
	// ready drops the edge after its grant, never later
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			{line_ready, sync_ready} <= 8'h00;
		else
			{line_ready, sync_ready} <= {(line_ready & ~line_grant) | ld_line,
				(sync_ready & ~sync_grant) | ld_sync};
	end
endmodule // fmc_src_model

/* File: verification/tb_fmc_forward_ctl.sv */
// bench: register, interrupt and forwarding tests over wishbone
// assumes fmc_src_model plays the receive ports
`timescale 1ns/1ns
module tb_fmc_forward_ctl;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	fmc_pkg::fmc_wb_req_s rq = '0; // bus request
	fmc_pkg::fmc_wb_rsp_s rs;
	logic [3:0] ld_line = 4'h0; // loads into the port model
	logic [3:0] ld_sync = 4'h0;
	logic [3:0] line_ready, sync_ready, line_grant, sync_grant;
	logic tx_ready = 1'b1;
	logic [3:0] rx_irq = 4'h0;
	logic tx_irq = 1'b0;
	logic irq;
	logic [31:0] q; // last read data
	logic [7:0] mv [4] = '{8'h04, 8'h08, 8'h44, 8'h4c}; // sync modes
	logic [3:0] hv [4] = '{4'h1, 4'h1, 4'h0, 4'h1}; // port0 line still held?
	int mismatches = 0;
	int n_checks = 0;
	initial forever #4 ref_clk = ~ref_clk;
	fmc_forward_ctl #(.SYNC_LOSS_CYC(20)) uut (.ref_clk(ref_clk), .reset(reset),
		.wb_req(rq), .wb_rsp(rs), .line_ready(line_ready), .sync_ready(sync_ready),
		.tx_ready(tx_ready), .rx_port_irq(rx_irq), .tx_port_irq(tx_irq),
		.line_grant(line_grant), .sync_grant(sync_grant), .irq(irq));
	fmc_src_model src (.ref_clk(ref_clk), .reset(reset), .ld_line(ld_line),
		.ld_sync(ld_sync), .line_grant(line_grant), .sync_grant(sync_grant),
		.line_ready(line_ready), .sync_ready(sync_ready));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	// one classic cycle; entered just after an edge, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		rq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		for (i = 0; i < 20; i++)
		begin
			@(posedge ref_clk);
			if (rs.ack === 1'b1)
				break;
		end
		q = rs.dat;
		rq <= '0;
		@(posedge ref_clk);
		if (i == 20)
		begin
			mismatches++;
			stop_test;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(1'b0, a, 8'h00);
		chk(n, e, q);
	endtask
	// wait for the next grant, {sync, line}; a missing one ends the run
	task automatic gw(input logic [7:0] e, input string n);
		int i;
		for (i = 0; i < 20; i++)
		begin
			@(posedge ref_clk);
			if ({sync_grant, line_grant} !== 8'h00)
				break;
		end
		chk(n, {24'h0, e}, {24'h0, sync_grant, line_grant});
		if (i == 20)
			stop_test;
	endtask
	// load the port model, then give the engine time to grant
	task automatic ld(input logic [3:0] l, input logic [3:0] s, input int n);
		ld_line <= l;
		ld_sync <= s;
		@(posedge ref_clk);
		{ld_line, ld_sync} <= 8'h00;
		repeat (n) @(posedge ref_clk);
	endtask
	initial
	begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(8'h80, 32'hf0, "fwd_off");
		rd(8'h84, 32'h01, "mode");
		rd(8'h88, 32'h00, "sync_sts");
		rd(8'h8c, 32'h00, "irq_en");
		rd(8'hfc, 32'h00, "unmapped");
		$display("reset test done");
		// pending shows without global enable, irq does not
		rx_irq <= 4'h1;
		wb(1'b1, 8'h8c, 8'h01);
		rd(8'h90, 32'h81, "pending");
		chk("irq gated", 32'h0, irq);
		for (int b = 0; b < 5; b++)
		begin
			wb(1'b1, 8'h8c, 8'h80 | (8'h01 << b));
			{tx_irq, rx_irq} <= 5'h01 << b;
			ld(4'h0, 4'h0, 3);
			chk("irq on", 32'h1, irq);
			wb(1'b1, 8'h8c, 8'h80 | (8'h01 << ((b + 1) % 5)));
			// irq is registered one edge after the new enable lands
			@(posedge ref_clk);
			chk("irq masked", 32'h0, irq);
		end
		{tx_irq, rx_irq} <= 5'h00;
		wb(1'b1, 8'h8c, 8'h00);
		$display("irq test done");
		// round robin, ports 1 and 3 off, output stalled first
		wb(1'b1, 8'h80, 8'ha0);
		tx_ready <= 1'b0;
		ld(4'h7, 4'h0, 12);
		chk("stall", 32'h7, line_ready);
		tx_ready <= 1'b1;
		gw(8'h01, "rr first");
		gw(8'h04, "rr next");
		ld(4'h0, 4'h0, 4);
		chk("rr", 32'h2, line_ready);
		wb(1'b1, 8'h80, 8'h00);
		ld(4'h0, 4'h0, 6);
		wb(1'b1, 8'h80, 8'hc0);
		for (int m = 0; m < 4; m++)
		begin
			wb(1'b1, 8'h84, mv[m]);
			rd(8'h84, {24'h0, mv[m]}, "mode rb");
			ld(4'h1, 4'h0, 12);
			chk("hold", {28'h0, hv[m]}, line_ready);
			ld(4'h2, 4'h0, 12);
			chk("all", 32'h0, line_ready);
		end
		$display("forward test done");
		// sync packets wait for all even with send_when_ready
		wb(1'b1, 8'h84, 8'h44);
		ld(4'h0, 4'h1, 12);
		chk("sync hold", 32'h1, sync_ready);
		ld(4'h0, 4'h2, 0);
		gw(8'h30, "sync grant");
		rd(8'h88, 32'h01, "synced");
		// unmasked own event shows as the transmitter source
		wb(1'b1, 8'ha4, 8'h02);
		rd(8'h90, 32'h10, "evt source");
		wb(1'b1, 8'ha4, 8'h00);
		wb(1'b0, 8'ha0, 8'h00);
		chk("gain evt", 32'h2, q & 32'h2);
		wb(1'b0, 8'ha0, 8'h00);
		chk("evt clr", 32'h0, q & 32'h2);
		ld(4'h0, 4'h3, 12);
		ld(4'h0, 4'h1, 32);
		ld(4'h0, 4'h2, 12);
		wb(1'b0, 8'h88, 8'h00);
		chk("fail set", 32'h4, q & 32'h4);
		wb(1'b0, 8'h88, 8'h00);
		chk("fail clr", 32'h0, q & 32'h4);
		rd(8'ha0, 32'h03, "evt both");
		wb(1'b1, 8'h84, 8'h01);
		rd(8'h88, 32'h00, "sync off");
		$display("sync test done");
		// second reset in mid-run restores the defaults
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(8'h80, 32'hf0, "fwd_off rst");
		rd(8'h84, 32'h01, "mode rst");
		$display("reset again test done");
		stop_test;
	end
endmodule // tb_fmc_forward_ctl
